// file: src/adc_calibration_gpio_regs.sv
// Purpose: Correction registers, result coding and port control of the converter
// Assumes: All pins synchronous to sys_clk; serial clock far slower than sys_clk
// Notes: Registers reached over the serial peripheral bus, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
`include "adc_corr_defs.svh"

module adc_calibration_gpio_regs (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe_n,
  input wire logic unipolar_mode,
  input wire logic offset_binary_format,
  input wire logic [23:0] raw_result,
  input wire logic raw_valid,
  input wire logic cal_busy,
  input wire adc_corr_pkg::cal_update_type self_cal_update,
  input wire adc_corr_pkg::cal_update_type sys_cal_update,
  output logic [15:0] conversion_result,
  output logic result_valid
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] port_control_r;
  adc_corr_pkg::correction_control_type correction_control_r;
  logic [15:0] conversion_result_r;
  logic [23:0] system_offset_coefficient_r;
  logic [23:0] system_gain_coefficient_r;
  logic [23:0] self_offset_coefficient_r;
  logic [23:0] self_gain_coefficient_r;
  logic result_valid_r;

  // ****************************************************************
  // Serial engine state
  // ****************************************************************
  adc_corr_pkg::spi_state_type state_r;
  adc_corr_pkg::spi_state_type state_nxt;
  logic sclk_prev_r;
  logic [4:0] bit_count_r;
  logic [4:0] bit_count_nxt;
  logic [4:0] length_r;
  logic [4:0] length_nxt;
  logic [4:0] addr_r;
  logic [4:0] addr_nxt;
  logic [23:0] shift_r;
  logic [23:0] shift_nxt;
  logic spi_sdo_r;
  logic spi_sdo_nxt;
  logic spi_sdo_oe_n_r;
  logic [3:0] gpio_out_r;
  logic [3:0] gpio_oe_n_r;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_fire;
  logic [23:0] wr_word;
  logic [15:0] code_nxt;

  // Register width in bits, zero for an unmapped address
  function automatic logic [4:0] reg_bits(input logic [4:0] addr);
    if (addr == `ADDR_PORT_CONTROL || addr == `ADDR_CORRECTION_CONTROL)
      return `BITS_BYTE;
    else if (addr == `ADDR_CONVERSION_RESULT)
      return `BITS_HALF;
    else if (addr == `ADDR_SYSTEM_OFFSET || addr == `ADDR_SYSTEM_GAIN ||
             addr == `ADDR_SELF_OFFSET || addr == `ADDR_SELF_GAIN)
      return `BITS_WORD;
    else
      return 5'h00;
  endfunction

  // Sign extension of a coefficient to the working width
  function automatic logic signed [47:0] sext24(input logic [23:0] v);
    return $signed({{24{v[23]}}, v});
  endfunction

  // Gain below two: unsigned coefficient with 23 fraction bits
  function automatic logic signed [47:0] gain_mul(
    input logic signed [47:0] x,
    input logic [23:0] c
  );
    logic signed [72:0] p;
    p = $signed({{25{x[47]}}, x}) * $signed({49'h0, c});
    return p[`GAIN_FRAC_BITS + 47:`GAIN_FRAC_BITS];
  endfunction

  assign sclk_rise = spi_sclk & ~sclk_prev_r;
  assign sclk_fall = ~spi_sclk & sclk_prev_r;
  assign wr_word = {shift_r[22:0], spi_sdi};

  // Edge detect on the serial clock; pins are already synchronous
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sclk_prev_r <= 1'b0;
    else
      sclk_prev_r <= spi_sclk;
  end

  // ****************************************************************
  // Serial transfer engine
  // ****************************************************************

  // Next-state logic: command byte, then data phase sized by the register
  always_comb
  begin
    state_nxt = state_r;
    bit_count_nxt = bit_count_r;
    length_nxt = length_r;
    addr_nxt = addr_r;
    shift_nxt = shift_r;
    spi_sdo_nxt = spi_sdo_r;
    wr_fire = 1'b0;
    if (spi_cs_n)
    begin
      state_nxt = adc_corr_pkg::SPI_IDLE;
      bit_count_nxt = 5'h00;
    end
    else
    begin
      case (state_r)
        adc_corr_pkg::SPI_IDLE:
        begin
          state_nxt = adc_corr_pkg::SPI_CMD;
          bit_count_nxt = 5'h00;
        end
        adc_corr_pkg::SPI_CMD:
        begin
          if (sclk_rise)
          begin
            shift_nxt = wr_word;
            bit_count_nxt = bit_count_r + 5'h01;
            if (bit_count_nxt == `CMD_BITS)
            begin
              addr_nxt = wr_word[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
              length_nxt = reg_bits(addr_nxt);
              bit_count_nxt = 5'h00;
              if (!wr_word[`CMD_START_BIT] || wr_word[`CMD_MODE_BIT] ||
                  length_nxt == 5'h00)
                state_nxt = adc_corr_pkg::SPI_HOLD;
              else if (wr_word[`CMD_READ_BIT])
              begin
                state_nxt = adc_corr_pkg::SPI_READ;
                shift_nxt = read_value(addr_nxt);
              end
              else
                state_nxt = adc_corr_pkg::SPI_WRITE;
            end
          end
        end
        adc_corr_pkg::SPI_WRITE:
        begin
          if (sclk_rise)
          begin
            shift_nxt = wr_word;
            bit_count_nxt = bit_count_r + 5'h01;
            if (bit_count_nxt == length_r)
            begin
              wr_fire = 1'b1;
              state_nxt = adc_corr_pkg::SPI_HOLD;
            end
          end
        end
        adc_corr_pkg::SPI_READ:
        begin
          if (sclk_fall)
          begin
            spi_sdo_nxt = shift_r[23];
            shift_nxt = {shift_r[22:0], 1'b0};
            bit_count_nxt = bit_count_r + 5'h01;
          end
          if (sclk_rise && bit_count_r == length_r)
            state_nxt = adc_corr_pkg::SPI_HOLD;
        end
        adc_corr_pkg::SPI_HOLD:
          state_nxt = adc_corr_pkg::SPI_HOLD;
        default:
          state_nxt = adc_corr_pkg::SPI_IDLE;
      endcase
    end
  end

  // Read value, left justified in 24 bits so the MSB leaves first
  function automatic logic [23:0] read_value(input logic [4:0] addr);
    if (addr == `ADDR_PORT_CONTROL)
      return {port_read(port_control_r), 16'h0000};
    else if (addr == `ADDR_CORRECTION_CONTROL)
      return {correction_control_r[7:1], 1'b0, 16'h0000};
    else if (addr == `ADDR_CONVERSION_RESULT)
      return {conversion_result_r, 8'h00};
    else if (addr == `ADDR_SYSTEM_OFFSET)
      return system_offset_coefficient_r;
    else if (addr == `ADDR_SYSTEM_GAIN)
      return system_gain_coefficient_r;
    else if (addr == `ADDR_SELF_OFFSET)
      return self_offset_coefficient_r;
    else if (addr == `ADDR_SELF_GAIN)
      return self_gain_coefficient_r;
    else
      return 24'h000000;
  endfunction

  // Input ports read the pin level, output ports read the stored bit
  function automatic logic [7:0] port_read(input logic [7:0] pc);
    logic [3:0] dir;
    dir = pc[`PORT_DIR_MSB:`PORT_DIR_LSB];
    return {dir, (dir & pc[`PORT_DATA_MSB:`PORT_DATA_LSB]) | (~dir & gpio_in)};
  endfunction

  // Engine registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= adc_corr_pkg::SPI_IDLE;
      bit_count_r <= 5'h00;
      length_r <= 5'h00;
      addr_r <= 5'h00;
      shift_r <= 24'h000000;
      spi_sdo_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      bit_count_r <= bit_count_nxt;
      length_r <= length_nxt;
      addr_r <= addr_nxt;
      shift_r <= shift_nxt;
      spi_sdo_r <= spi_sdo_nxt;
    end
  end

  // Data line released whenever the bus is deselected
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      spi_sdo_oe_n_r <= 1'b1;
    else
      spi_sdo_oe_n_r <= spi_cs_n | (state_nxt != adc_corr_pkg::SPI_READ);
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Port and correction control bytes
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_control_r <= `RST_PORT_CONTROL;
      correction_control_r <= `RST_CORRECTION_CONTROL;
    end
    else if (wr_fire)
    begin
      if (addr_r == `ADDR_PORT_CONTROL)
        port_control_r <= wr_word[7:0];
      else if (addr_r == `ADDR_CORRECTION_CONTROL)
        correction_control_r <= {wr_word[7:1], 1'b0};
    end
  end

  // Port pins follow the control byte
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gpio_out_r <= 4'h0;
      gpio_oe_n_r <= 4'hf;
    end
    else
    begin
      gpio_out_r <= port_control_r[`PORT_DATA_MSB:`PORT_DATA_LSB];
      gpio_oe_n_r <= ~port_control_r[`PORT_DIR_MSB:`PORT_DIR_LSB];
    end
  end

  // System coefficients; a calibration store beats a host write in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      system_offset_coefficient_r <= `RST_COEFFICIENT;
      system_gain_coefficient_r <= `RST_COEFFICIENT;
    end
    else if (sys_cal_update.valid)
    begin
      system_offset_coefficient_r <= sys_cal_update.offset;
      system_gain_coefficient_r <= sys_cal_update.gain;
    end
    else if (wr_fire && !cal_busy)
    begin
      if (addr_r == `ADDR_SYSTEM_OFFSET)
        system_offset_coefficient_r <= wr_word;
      else if (addr_r == `ADDR_SYSTEM_GAIN)
        system_gain_coefficient_r <= wr_word;
    end
  end

  // Self coefficients; writes during a calibration are dropped
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      self_offset_coefficient_r <= `RST_COEFFICIENT;
      self_gain_coefficient_r <= `RST_COEFFICIENT;
    end
    else if (self_cal_update.valid)
    begin
      self_offset_coefficient_r <= self_cal_update.offset;
      self_gain_coefficient_r <= self_cal_update.gain;
    end
    else if (wr_fire && !cal_busy)
    begin
      if (addr_r == `ADDR_SELF_OFFSET)
        self_offset_coefficient_r <= wr_word;
      else if (addr_r == `ADDR_SELF_GAIN)
        self_gain_coefficient_r <= wr_word;
    end
  end

  // ****************************************************************
  // Correction path
  // ****************************************************************

  // Stages run in a fixed order; wide accumulator keeps the offset stages exact, gain stages drop their 23 fraction bits
  always_comb
  begin
    logic signed [47:0] acc;
    logic signed [47:0] scaled;
    acc = sext24(raw_result);
    scaled = 48'sh0;
    if (!correction_control_r.self_offset_bypass)
      acc = acc - sext24(self_offset_coefficient_r);
    if (!correction_control_r.self_gain_bypass)
      acc = gain_mul(acc, self_gain_coefficient_r);
    if (!correction_control_r.system_offset_bypass)
      acc = acc - sext24(system_offset_coefficient_r);
    if (!correction_control_r.system_gain_bypass)
      acc = gain_mul(acc, system_gain_coefficient_r);
    if (unipolar_mode)
      acc = acc <<< `UNIPOLAR_SHIFT;
    acc = acc <<< correction_control_r.digital_gain_select;
    scaled = acc >>> `RESULT_SHIFT;
    if (unipolar_mode)
    begin
      // Straight binary clipped to the code range
      if (scaled > `SAT_UNIPOLAR_MAX)
        scaled = `SAT_UNIPOLAR_MAX;
      else if (scaled < `SAT_UNIPOLAR_MIN)
        scaled = `SAT_UNIPOLAR_MIN;
      code_nxt = scaled[15:0];
    end
    else
    begin
      if (scaled > `SAT_BIPOLAR_MAX)
        scaled = `SAT_BIPOLAR_MAX;
      else if (scaled < `SAT_BIPOLAR_MIN)
        scaled = `SAT_BIPOLAR_MIN;
      if (offset_binary_format)
        code_nxt = scaled[15:0] ^ `OFFSET_BINARY_FLIP;
      else
        code_nxt = scaled[15:0];
    end
  end

  // Result register is loaded only by the converter, never by the bus
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conversion_result_r <= `RST_RESULT;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_valid_r <= raw_valid;
      if (raw_valid)
        conversion_result_r <= code_nxt;
    end
  end

  assign spi_sdo = spi_sdo_r;
  assign spi_sdo_oe_n = spi_sdo_oe_n_r;
  assign gpio_out = gpio_out_r;
  assign gpio_oe_n = gpio_oe_n_r;
  assign conversion_result = conversion_result_r;
  assign result_valid = result_valid_r;

endmodule
`default_nettype wire

// file: src/adc_corr_defs.svh
// Purpose: Named constants for the correction and port control block
// Assumes: Included by bare name wherever a constant is needed
// Notes: Definitions only
`ifndef ADC_CORR_DEFS_SVH
`define ADC_CORR_DEFS_SVH

// ****************************************************************
// Register addresses on the serial bus
// ****************************************************************
`define ADDR_PORT_CONTROL 5'h02
`define ADDR_CORRECTION_CONTROL 5'h03
`define ADDR_CONVERSION_RESULT 5'h04
`define ADDR_SYSTEM_OFFSET 5'h05
`define ADDR_SYSTEM_GAIN 5'h06
`define ADDR_SELF_OFFSET 5'h07
`define ADDR_SELF_GAIN 5'h08

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_PORT_CONTROL 8'h0f
`define RST_CORRECTION_CONTROL 8'h1e
`define RST_COEFFICIENT 24'h000000
`define RST_RESULT 16'h0000

// ****************************************************************
// Field positions
// ****************************************************************
`define PORT_DIR_MSB 7
`define PORT_DIR_LSB 4
`define PORT_DATA_MSB 3
`define PORT_DATA_LSB 0
`define CMD_START_BIT 7
`define CMD_MODE_BIT 6
`define CMD_ADDR_MSB 5
`define CMD_ADDR_LSB 1
`define CMD_READ_BIT 0

// ****************************************************************
// Transfer lengths in bits
// ****************************************************************
`define CMD_BITS 5'd8
`define BITS_BYTE 5'd8
`define BITS_HALF 5'd16
`define BITS_WORD 5'd24

// ****************************************************************
// Arithmetic constants
// ****************************************************************
`define GAIN_FRAC_BITS 23
`define RESULT_SHIFT 8
`define UNIPOLAR_SHIFT 1
`define SAT_BIPOLAR_MAX 48'sh0000_0000_7fff
`define SAT_BIPOLAR_MIN 48'shffff_ffff_8000
`define SAT_UNIPOLAR_MAX 48'sh0000_0000_ffff
`define SAT_UNIPOLAR_MIN 48'sh0000_0000_0000
`define OFFSET_BINARY_FLIP 16'h8000

`endif

// file: src/adc_corr_pkg.sv
// Purpose: Types shared by the correction and port control block
// Assumes: Constants live in adc_corr_defs.svh
// Notes: Nothing here is imported; users write adc_corr_pkg::name
package adc_corr_pkg;

  // Correction control register layout, high bit first
  typedef struct packed {
    logic [2:0] digital_gain_select;
    logic system_gain_bypass;
    logic system_offset_bypass;
    logic self_gain_bypass;
    logic self_offset_bypass;
    logic reserved;
  } correction_control_type;

  // Coefficient pair stored by an on-demand calibration
  typedef struct packed {
    logic valid;
    logic [23:0] offset;
    logic [23:0] gain;
  } cal_update_type;

  // Serial transfer phases, one-hot
  typedef enum logic [4:0] {
    SPI_IDLE = 5'b00001,
    SPI_CMD = 5'b00010,
    SPI_WRITE = 5'b00100,
    SPI_READ = 5'b01000,
    SPI_HOLD = 5'b10000
  } spi_state_type;

endpackage

// file: testbench/adc_calibration_gpio_regs_monitor.sv
// Purpose: Port-level checks of the correction and port control block
// Assumes: Bound to the top module; single clock domain
// Notes: Observes only; serial clock phases last at least two system clocks
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_gpio_regs_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe_n,
  input wire logic raw_valid,
  input wire logic [15:0] conversion_result,
  input wire logic result_valid
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Result timing against the raw strobe
  a_valid_follows_raw: assert property (raw_valid |=> result_valid)
    else $error("result_valid missing after raw_valid");
  a_valid_needs_raw: assert property (!raw_valid |=> !result_valid)
    else $error("result_valid without raw_valid");
  // Host writes never disturb the result; only a conversion does
  a_result_holds: assert property (!raw_valid |=> $stable(conversion_result))
    else $error("conversion_result changed without a conversion");
  // Output driver only inside a selected frame
  a_oe_needs_cs: assert property (!spi_sdo_oe_n |-> !$past(spi_cs_n))
    else $error("sdo driven while not selected");
  a_sdo_idle_off: assert property (spi_cs_n [*2] |-> spi_sdo_oe_n)
    else $error("sdo still driven after deselect");
  // Data may only move after a falling serial clock
  a_sdo_steady_high: assert property (
    !spi_sdo_oe_n && !$past(spi_sdo_oe_n) && spi_sclk && $past(spi_sclk) && $past(spi_sclk, 2)
    |-> $stable(spi_sdo)) else $error("sdo moved while sclk high");
  a_oe_after_rise: assert property (
    $fell(spi_sdo_oe_n) |-> $past(spi_sclk) && !spi_cs_n) else $error("read phase started badly");
  // Port pins only change as a result of a frame
  a_gpio_steady: assert property (
    spi_cs_n [*3] ##0 !$past(rst, 3) |-> $stable(gpio_out) && $stable(gpio_oe_n))
    else $error("port pins changed outside a frame");
endmodule
`default_nettype wire

// file: testbench/spi_host_model.sv
// Purpose: Host controller model on the serial register bus
// Assumes: Mode 0; each sclk phase lasts three system clocks
// Notes: A released data line reads as a toggling pattern, never a held value
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic sys_clk,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  logic sdo_line = 1'b0;

  // Undriven line must not look like the last bit the device gave
  always @(posedge sys_clk)
    sdo_line <= spi_sdo_oe_n ? ~sdo_line : spi_sdo;

  initial
  begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi = 1'b0;
  end

  // One frame: command byte then nb data bits, MSB first both ways
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nb,
                      output logic [23:0] rd);
    logic [31:0] sh;
    sh = {cmd, 24'h000000} | ({8'h00, wd} << (24 - nb));
    rd = 24'h000000;
    spi_cs_n = 1'b0;
    for (int i = 0; i < 8 + nb; i++)
    begin
      spi_sdi = sh[31];
      sh = sh << 1;
      repeat (3) @(negedge sys_clk);
      spi_sclk = 1'b1;
      rd = {rd[22:0], sdo_line};
      repeat (3) @(negedge sys_clk);
      spi_sclk = 1'b0;
    end
    rd = rd & (24'hffffff >> (24 - nb));
    repeat (3) @(negedge sys_clk);
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/adc_calibration_gpio_regs_tb.sv
// Purpose: Self-checking bench for the correction and port control block
// Assumes: Inputs change on the falling system clock edge
// Notes: Gains and offsets picked so every gain stage divides exactly
`timescale 1ns/1ps
`default_nettype none
`include "adc_corr_defs.svh"
module adc_calibration_gpio_regs_tb;
  logic sys_clk, rst, unipolar_mode, offset_binary_format, raw_valid, cal_busy;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n, result_valid;
  logic [3:0] gpio_out, gpio_oe_n, pin_ext;
  wire logic [3:0] gpio_in;
  logic [23:0] raw_result, soc, system_gain_coefficient, self_offset_coefficient, self_gain_coefficient, rdv;
  logic [15:0] conversion_result, last_code;
  logic [7:0] cc;
  adc_corr_pkg::cal_update_type self_cal_update, sys_cal_update;
  int num_errors = 0;
  int n_tests = 0;

  // Pin level: the device wins where it drives, the outside elsewhere
  assign gpio_in = (~gpio_oe_n & gpio_out) | (gpio_oe_n & pin_ext);

  adc_calibration_gpio_regs adc_calibration_gpio_regs_inst (.sys_clk, .rst, .spi_sclk,
    .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n, .gpio_in, .gpio_out, .gpio_oe_n,
    .unipolar_mode, .offset_binary_format, .raw_result, .raw_valid, .cal_busy,
    .self_cal_update, .sys_cal_update, .conversion_result, .result_valid);
  spi_host_model spi_host_model_inst (.sys_clk, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo,
    .spi_sdo_oe_n);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic int nbits(logic [4:0] a);
    return (a < 5'h04) ? 8 : (a == 5'h04) ? 16 : 24;
  endfunction

  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    spi_host_model_inst.xfer({2'b10, a, 1'b0}, d, nbits(a), rdv);
  endtask

  task automatic rd(input logic [4:0] a, input logic [23:0] exp);
    spi_host_model_inst.xfer({2'b10, a, 1'b1}, 24'h000000, nbits(a), rdv);
    chk(rdv, exp);
  endtask

  // Expected code, stage by stage in the fixed correction order
  function automatic logic [15:0] ref_code(logic [23:0] raw);
    logic signed [63:0] a;
    a = $signed(raw);
    if (!cc[1]) a = a - $signed(self_offset_coefficient);
    if (!cc[2]) a = (a * $signed({40'h0, self_gain_coefficient})) >>> 23;
    if (!cc[3]) a = a - $signed(soc);
    if (!cc[4]) a = (a * $signed({40'h0, system_gain_coefficient})) >>> 23;
    if (unipolar_mode) a = a <<< 1;
    a = (a <<< cc[7:5]) >>> 8;
    if (unipolar_mode) a = (a < 0) ? 64'sh0 : (a > 64'shffff) ? 64'shffff : a;
    else a = (a < -64'sh8000) ? -64'sh8000 : (a > 64'sh7fff) ? 64'sh7fff : a;
    return a[15:0] ^ ((!unipolar_mode && offset_binary_format) ? 16'h8000 : 16'h0000);
  endfunction

  task automatic conv(input logic [23:0] raw);
    raw_result = raw;
    raw_valid = 1'b1;
    last_code = ref_code(raw);
    @(negedge sys_clk);
    raw_valid = 1'b0;
    chk(24'(result_valid), 24'h000001);
    chk(24'(conversion_result), 24'(last_code));
  endtask

  task automatic t_reset;
    // Port drive bits take the reset data nibble one edge after release
    @(negedge sys_clk);
    chk(24'(gpio_oe_n), 24'h00000f);
    chk(24'(gpio_out), 24'h00000f);
    rd(`ADDR_PORT_CONTROL, 24'(pin_ext));
    rd(`ADDR_CORRECTION_CONTROL, 24'h00001e);
    for (int a = 5; a <= 8; a++) rd(5'(a), 24'h000000);
    rd(`ADDR_CONVERSION_RESULT, 24'h000000);
    $display("test reset done");
  endtask

  task automatic t_port;
    wr(`ADDR_PORT_CONTROL, 24'h000085);
    chk(24'(gpio_oe_n), 24'h000007);
    chk(24'(gpio_out), 24'h000005);
    rd(`ADDR_PORT_CONTROL, {16'h0, 5'h10, pin_ext[2:0]});
    pin_ext = 4'h5;
    rd(`ADDR_PORT_CONTROL, 24'h000085);
    wr(`ADDR_PORT_CONTROL, 24'h0000fa);
    chk(24'(gpio_oe_n), 24'h000000);
    chk(24'(gpio_out), 24'h00000a);
    rd(`ADDR_PORT_CONTROL, 24'h0000fa);
    $display("test port done");
  endtask

  task automatic t_coding;
    logic [23:0] raws [5] = '{24'h000000, 24'h400000, 24'h7fffff, 24'h800000, 24'hc00000};
    for (int m = 0; m < 4; m++)
    begin
      {unipolar_mode, offset_binary_format} = 2'(m);
      foreach (raws[i]) conv(raws[i]);
    end
    {unipolar_mode, offset_binary_format} = 2'b00;
    $display("test coding done");
  endtask

  task automatic t_corr;
    self_offset_coefficient = 24'h000100;
    self_gain_coefficient = 24'h600000;
    soc = 24'hffff00;
    system_gain_coefficient = 24'ha00000;
    wr(`ADDR_SYSTEM_OFFSET, soc);
    wr(`ADDR_SYSTEM_GAIN, system_gain_coefficient);
    wr(`ADDR_SELF_OFFSET, self_offset_coefficient);
    wr(`ADDR_SELF_GAIN, self_gain_coefficient);
    rd(`ADDR_SYSTEM_OFFSET, soc);
    for (int m = 0; m < 2; m++)
    begin
      unipolar_mode = m[0];
      for (int k = 0; k < 12; k++)
      begin
        cc = (k < 4) ? (8'h1e ^ (8'h02 << k)) : {3'(k - 4), 5'h00};
        wr(`ADDR_CORRECTION_CONTROL, 24'(cc));
        conv(24'h123450);
        conv(24'hf00000);
      end
    end
    unipolar_mode = 1'b0;
    $display("test corrections done");
  endtask

  task automatic t_rdonly;
    wr(`ADDR_CONVERSION_RESULT, 24'h005a5a);
    rd(`ADDR_CONVERSION_RESULT, 24'(last_code));
    wr(5'h1f, 24'hffffff);
    // Commands with a bad start or mode bit must leave the control byte alone
    spi_host_model_inst.xfer({2'b11, `ADDR_CORRECTION_CONTROL, 1'b0}, 24'h0000ff, 8, rdv);
    spi_host_model_inst.xfer({2'b00, `ADDR_CORRECTION_CONTROL, 1'b0}, 24'h0000ff, 8, rdv);
    rd(`ADDR_CORRECTION_CONTROL, 24'(cc));
    $display("test read-only done");
  endtask

  task automatic t_persist;
    cal_busy = 1'b1;
    wr(`ADDR_SYSTEM_OFFSET, 24'h001230);
    cal_busy = 1'b0;
    rd(`ADDR_SYSTEM_OFFSET, soc);
    soc = 24'h000040;
    system_gain_coefficient = 24'h700000;
    self_offset_coefficient = 24'hffffc0;
    self_gain_coefficient = 24'h900000;
    sys_cal_update = {1'b1, soc, system_gain_coefficient};
    self_cal_update = {1'b1, self_offset_coefficient, self_gain_coefficient};
    @(negedge sys_clk);
    sys_cal_update.valid = 1'b0;
    self_cal_update.valid = 1'b0;
    for (int a = 5; a <= 8; a++) rd(5'(a), (a == 5) ? soc : (a == 6) ? system_gain_coefficient : (a == 7) ? self_offset_coefficient : self_gain_coefficient);
    cc = 8'h00;
    wr(`ADDR_CORRECTION_CONTROL, 24'(cc));
    conv(24'h200000);
    $display("test persistence done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    {unipolar_mode, offset_binary_format, raw_valid, cal_busy} = 4'h0;
    raw_result = 24'h000000;
    self_cal_update = '0;
    sys_cal_update = '0;
    pin_ext = 4'ha;
    cc = 8'h1e;
    {soc, system_gain_coefficient, self_offset_coefficient, self_gain_coefficient} = '0;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    t_reset;
    t_port;
    t_coding;
    t_corr;
    t_rdonly;
    t_persist;
    tally_and_finish;
  end

  // Watchdog: roughly eight times the expected run length
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    tally_and_finish;
  end
endmodule

bind adc_calibration_gpio_regs adc_calibration_gpio_regs_monitor
  adc_calibration_gpio_regs_monitor_inst (.sys_clk, .rst, .spi_sclk, .spi_cs_n, .spi_sdo,
  .spi_sdo_oe_n, .gpio_out, .gpio_oe_n, .raw_valid, .conversion_result, .result_valid);
`default_nettype wire
